// ### mmc_pkg.sv
`default_nettype none
package mmc_pkg;
	// ----------------------------------------
	// Clock and serial rates
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int PULSE_US = 1000; // Energy pulse width
	localparam logic [3:0] RC_1200 = 4'h3;
	localparam logic [3:0] RC_2400 = 4'h4;
	localparam logic [3:0] RC_4800 = 4'h5;
	localparam logic [3:0] RC_9600 = 4'h6;
	localparam logic [1:0] FMT_8N1 = 2'h0;
	localparam logic [1:0] FMT_8E1 = 2'h1;
	localparam logic [1:0] FMT_8O1 = 2'h2;
	localparam logic [1:0] FMT_8N2 = 2'h3;
	// ----------------------------------------
	// Register map and values
	// ----------------------------------------
	localparam logic [15:0] REG_MODEL_A = 16'h0000;
	localparam logic [15:0] REG_MODEL_B = 16'h0001;
	localparam logic [15:0] REG_VRANGE = 16'h0002;
	localparam logic [15:0] REG_IRANGE = 16'h0003;
	localparam logic [15:0] REG_CFG = 16'h0004;
	localparam logic [15:0] REG_CFG_END = 16'h0005;
	localparam logic [15:0] REG_EN_HI = 16'h000C;
	localparam logic [15:0] REG_EN_LO = 16'h000D;
	localparam logic [15:0] REG_EN_END = 16'h000E;
	localparam logic [15:0] VRANGE_V = 16'h00FA;
	localparam logic [15:0] IRANGE_DA = 16'h0032;
	localparam logic [15:0] CFG_RESET = 16'h0105;
	localparam logic [15:0] UPDATE_MS = 16'h03E8;
	localparam logic [15:0] CT_RATIO = 16'h0001;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	// ----------------------------------------
	// Frame layout and protocol constants
	// ----------------------------------------
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WRITE = 8'h10;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_OK = 16'h0000;
	localparam logic [15:0] MAX_QTY = 16'h0008;
	localparam logic [15:0] WR_QTY = 16'h0001;
	localparam logic [7:0] WR_BCNT = 8'h02;
	localparam logic [5:0] GAP_BITS = 6'h27; // 3.5 chars of 11 bits
	localparam int BUF_LEN = 12;
	localparam logic [4:0] NB_MAX = 5'h0C;
	localparam logic [4:0] LEN_RD_REQ = 5'h08;
	localparam logic [4:0] LEN_WR_REQ = 5'h0B;
	localparam logic [4:0] RD_HDR = 5'h03;
	localparam logic [4:0] WR_HDR = 5'h06;
	localparam logic [4:0] CRC_LEN = 5'h02;
	localparam int B_ADDR = 0;
	localparam int B_FN = 1;
	localparam int B_SAH = 2;
	localparam int B_SAL = 3;
	localparam int B_QH = 4;
	localparam int B_QL = 5;
	localparam int B_BCNT = 6;
	localparam int B_DH = 7;
	localparam int B_DL = 8;
	localparam logic [3:0] DATA_LAST = 4'h8;
	localparam logic [3:0] PAR_IDX = 4'h9;
	localparam logic [3:0] STOP_1 = 4'h9;
	localparam logic [3:0] STOP_2 = 4'hA;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_RXB = 2'b01,
		S_EVAL = 2'b11,
		S_TX = 2'b10
	} mmc_state_t;

	// Field views of the configuration word
	function automatic logic [7:0] cfg_addr(input logic [15:0] w);
		return w[15:8];
	endfunction : cfg_addr

	function automatic logic [1:0] cfg_fmt(input logic [15:0] w);
		return w[7:6];
	endfunction : cfg_fmt

	function automatic logic [3:0] cfg_rate(input logic [15:0] w);
		return w[3:0];
	endfunction : cfg_rate

	// One byte of the reflected CRC, LSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte
endpackage : mmc_pkg
`default_nettype wire

// ### mmc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mmc_regs
	import mmc_pkg::*;
#(
	parameter int P_CLK_HZ = CLK_HZ,
	parameter int P_PULSE_CYC = PULSE_US * (CLK_HZ / US_PER_S),
	parameter logic [15:0] P_MODEL_A = 16'h5A01, // Arbitrary identity value
	parameter logic [15:0] P_MODEL_B = 16'h5A02 // Arbitrary identity value
)(
	// Clock, enable, reset
	input wire logic i_core_clk,
	input wire logic i_ce,
	input wire logic i_sys_rst,
	// Serial link
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_led,
	// Metering side
	input wire logic i_energy_tick,
	input wire logic i_nv_load,
	input wire logic [31:0] i_nv_energy,
	output logic [31:0] o_energy,
	output logic o_energy_pulse_out,
	// Settings seen by the rest of the module
	output logic [15:0] o_cfg_word,
	output logic [15:0] o_update_ms,
	output logic [15:0] o_ct_ratio
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if ((P_CLK_HZ / BAUD_1200) > 65535 || (P_CLK_HZ / BAUD_9600) < 4) begin : g_clk_chk
		$error("Clock rate cannot serve the bit timer");
	end
	if (P_PULSE_CYC < 1) begin : g_pls_chk
		$error("Pulse width must be at least one cycle");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mmc_state_t st; // Link sequencer
		logic s1; // Receive synchroniser
		logic s2;
		logic s3;
		logic rxf; // Filtered receive level
		logic [15:0] tmr; // Bit period timer
		logic [3:0] bi; // Bit index in character
		logic [7:0] sh; // Receive shifter
		logic bad; // Frame error seen
		logic [5:0] gap; // Idle bit times
		logic [4:0] nb; // Bytes received
		logic [BUF_LEN-1:0][7:0] buff; // Request bytes
		logic [15:0] crc; // Running CRC
		logic [15:0] cfg; // Live settings
		logic [15:0] pcfg; // Settings waiting for reply end
		logic pend;
		logic rd; // Reply is a read
		logic [4:0] ti; // Reply byte index
		logic [4:0] tl; // Reply length
		logic [7:0] tb; // Byte on the wire
		logic txd;
		logic led;
		logic [31:0] en; // Energy count
		logic [31:0] pc; // Pulse width count
		logic pls;
	} mmc_st_t;

	localparam mmc_st_t ST_RST = '{
		st: S_IDLE, s1: 1'b1, s2: 1'b1, s3: 1'b1, rxf: 1'b1,
		crc: CRC_INIT, cfg: CFG_RESET, txd: 1'b1, led: 1'b1,
		default: '0
	};

	mmc_st_t q; // Registered state
	mmc_st_t d; // Next state

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Cycles per bit; unknown codes never reach cfg
	function automatic logic [15:0] bit_cyc(input logic [3:0] rc);
		case (rc)
			RC_1200: return 16'(P_CLK_HZ / BAUD_1200);
			RC_2400: return 16'(P_CLK_HZ / BAUD_2400);
			RC_4800: return 16'(P_CLK_HZ / BAUD_4800);
			default: return 16'(P_CLK_HZ / BAUD_9600);
		endcase
	endfunction : bit_cyc

	function automatic logic has_par(input logic [1:0] f);
		return (f == FMT_8E1) || (f == FMT_8O1);
	endfunction : has_par

	// Even parity makes the ones count even
	function automatic logic par_bit(input logic [1:0] f, input logic [7:0] b);
		return (f == FMT_8O1) ? ~^b : ^b;
	endfunction : par_bit

	// Index of the final stop bit
	function automatic logic [3:0] last_idx(input logic [1:0] f);
		return (f == FMT_8N1) ? STOP_1 : STOP_2;
	endfunction : last_idx

	// Line level for bit i of a character
	function automatic logic tx_bit(input logic [1:0] f, input logic [7:0] b, input logic [3:0] i);
		if (i == 4'h0) begin
			return 1'b0;
		end else if (i <= DATA_LAST) begin
			return b[3'(i - 4'h1)];
		end else if (i == PAR_IDX && has_par(f)) begin
			return par_bit(f, b);
		end else begin
			return 1'b1;
		end
	endfunction : tx_bit

	// Register decode for reads
	function automatic logic [15:0] reg_word(input mmc_st_t s, input logic [15:0] a);
		if (a == REG_MODEL_A) begin
			return P_MODEL_A;
		end else if (a == REG_MODEL_B) begin
			return P_MODEL_B;
		end else if (a == REG_VRANGE) begin
			return VRANGE_V;
		end else if (a == REG_IRANGE) begin
			return IRANGE_DA;
		end else if (a == REG_CFG) begin
			return s.cfg;
		end else if (a == REG_EN_HI) begin
			return s.en[31:16];
		end else if (a == REG_EN_LO) begin
			return s.en[15:0];
		end else begin
			return WORD_ZERO;
		end
	endfunction : reg_word

	// Byte k of the reply; c is the CRC so far
	function automatic logic [7:0] resp_byte(input mmc_st_t s, input logic [4:0] k,
			input logic [15:0] c);
		logic [4:0] off;
		logic [15:0] w;
		off = k - RD_HDR;
		w = reg_word(s, {s.buff[B_SAH], s.buff[B_SAL]} + {12'h000, off[4:1]});
		if (k == s.tl - CRC_LEN) begin
			return c[7:0];
		end else if (k == s.tl - 5'h01) begin
			return c[15:8];
		end else if (!s.rd || k < 5'(B_BCNT - 4)) begin
			return s.buff[k]; // Echo header
		end else if (k == 5'(B_BCNT - 4)) begin
			return {s.buff[B_QL][6:0], 1'b0}; // Byte count
		end else begin
			return off[0] ? w[7:0] : w[15:8];
		end
	endfunction : resp_byte

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] bitc;
		logic [15:0] sa;
		logic [15:0] qty;
		logic [15:0] nw;
		logic [1:0] fmt;
		logic tick;
		logic frm_ok;
		logic rd_ok;
		logic wr_ok;
		d = q;
		fmt = cfg_fmt(q.cfg);
		bitc = bit_cyc(cfg_rate(q.cfg));
		tick = (q.tmr == WORD_ZERO);
		sa = {q.buff[B_SAH], q.buff[B_SAL]};
		qty = {q.buff[B_QH], q.buff[B_QL]};
		nw = {q.buff[B_DH], q.buff[B_DL]};
		// A whole good frame leaves the CRC at zero
		frm_ok = !q.bad && (q.crc == CRC_OK);
		rd_ok = (q.buff[B_FN] == FN_READ) && (q.nb == LEN_RD_REQ)
			&& (qty != WORD_ZERO) && (qty <= MAX_QTY)
			&& ((sa <= REG_CFG && sa + qty <= REG_CFG_END)
			|| (sa >= REG_EN_HI && sa <= REG_EN_LO && sa + qty <= REG_EN_END));
		wr_ok = (q.buff[B_FN] == FN_WRITE) && (q.nb == LEN_WR_REQ)
			&& (sa == REG_CFG) && (qty == WR_QTY) && (q.buff[B_BCNT] == WR_BCNT)
			&& (cfg_rate(nw) >= RC_1200) && (cfg_rate(nw) <= RC_9600)
			&& (cfg_addr(nw) != ADDR_BCAST);
		if (i_ce) begin
			// Three stages; a level counts once two agree
			d.s1 = i_rxd;
			d.s2 = q.s1;
			d.s3 = q.s2;
			if (q.s2 == q.s3) begin
				d.rxf = q.s3;
			end
			if (!tick) begin
				d.tmr = q.tmr - 16'h0001;
			end
			// Energy count; the NV store reloads it
			if (i_nv_load) begin
				d.en = i_nv_energy;
			end else if (i_energy_tick) begin
				d.en = q.en + 32'h0000_0001;
			end
			// Fixed width pulse per energy tick
			if (i_energy_tick) begin
				d.pls = 1'b1;
				d.pc = 32'(P_PULSE_CYC - 1);
			end else if (q.pc != 32'h0000_0000) begin
				d.pc = q.pc - 32'h0000_0001;
			end else begin
				d.pls = 1'b0;
			end
			case (q.st)
				S_IDLE: begin
					if (!q.rxf) begin
						// Start bit: aim at mid-bit
						d.st = S_RXB;
						d.tmr = bitc >> 1;
						d.bi = 4'h0;
					end else if (tick) begin
						d.tmr = bitc - 16'h0001;
						if (q.gap != GAP_BITS) begin
							d.gap = q.gap + 6'h01;
						end else if (q.nb != 5'h00) begin
							d.st = S_EVAL; // Silence ends the frame
						end
					end
				end
				S_RXB: begin
					if (tick) begin
						d.tmr = bitc - 16'h0001;
						d.bi = q.bi + 4'h1;
						if (q.bi == 4'h0) begin
							if (q.rxf) begin
								d.st = S_IDLE; // Glitch, not a start bit
							end
						end else if (q.bi <= DATA_LAST) begin
							d.sh = {q.rxf, q.sh[7:1]};
						end else if (q.bi == last_idx(fmt)) begin
							// Stop bit; store the byte
							if (!q.rxf) begin
								d.bad = 1'b1;
							end
							if (q.nb < NB_MAX) begin
								d.buff[q.nb] = q.sh;
							end else begin
								d.bad = 1'b1; // Too long for any request
							end
							if (q.nb != 5'h1F) begin
								d.nb = q.nb + 5'h01;
							end
							d.crc = crc_byte(q.crc, q.sh);
							d.gap = 6'h00;
							d.st = S_IDLE;
						end else if (has_par(fmt)) begin
							if (q.rxf != par_bit(fmt, q.sh)) begin
								d.bad = 1'b1;
							end
						end else if (!q.rxf) begin
							d.bad = 1'b1; // First of two stops
						end
					end
				end
				S_EVAL: begin
					d.st = S_IDLE;
					d.nb = 5'h00;
					d.crc = CRC_INIT;
					d.bad = 1'b0;
					d.gap = 6'h00;
					// Broadcast write acts at once, silently
					if (frm_ok && wr_ok && q.buff[B_ADDR] == ADDR_BCAST) begin
						d.cfg = nw;
					end
					if (frm_ok && (rd_ok || wr_ok) && q.buff[B_ADDR] == cfg_addr(q.cfg)) begin
						d.st = S_TX;
						d.rd = rd_ok;
						d.pend = wr_ok;
						d.pcfg = nw;
						d.tl = rd_ok ? (RD_HDR + CRC_LEN + {qty[3:0], 1'b0}) : (WR_HDR + CRC_LEN);
						d.ti = 5'h00;
						d.bi = 4'h0;
						d.txd = 1'b0;
						d.tmr = bitc - 16'h0001;
						d.tb = resp_byte(d, 5'h00, CRC_INIT);
					end
				end
				S_TX: begin
					if (tick) begin
						d.tmr = bitc - 16'h0001;
						if (q.bi != last_idx(fmt)) begin
							d.bi = q.bi + 4'h1;
							d.txd = tx_bit(fmt, q.tb, d.bi);
						end else begin
							if (q.ti < q.tl - CRC_LEN) begin
								d.crc = crc_byte(q.crc, q.tb);
							end
							if (q.ti == q.tl - 5'h01) begin
								// Reply done; old settings held until now
								d.st = S_IDLE;
								d.txd = 1'b1;
								d.crc = CRC_INIT;
								d.gap = 6'h00;
								if (q.pend) begin
									d.cfg = q.pcfg;
									d.pend = 1'b0;
								end
							end else begin
								d.ti = q.ti + 5'h01;
								d.bi = 4'h0;
								d.txd = 1'b0;
								d.tb = resp_byte(q, d.ti, d.crc);
							end
						end
					end
				end
				default: begin
					d.st = S_IDLE;
				end
			endcase
			// Indicator follows the wire only while sending
			d.led = (d.st == S_TX) ? d.txd : 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_txd = q.txd;
	assign o_led = q.led;
	assign o_energy = q.en;
	assign o_energy_pulse_out = q.pls;
	assign o_cfg_word = q.cfg;
	assign o_update_ms = UPDATE_MS;
	assign o_ct_ratio = CT_RATIO;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_foreign;
		i_ce && q.st == S_EVAL && q.buff[B_ADDR] != cfg_addr(q.cfg);
	endsequence
	sequence s_crc_bad;
		i_ce && q.st == S_EVAL && q.crc != CRC_OK;
	endsequence
	sequence s_tx_enter;
		$rose(q.st == S_TX);
	endsequence

	rst_cfg_a: assert property ($fell(i_sys_rst) |-> q.cfg == CFG_RESET)
		else $error("Config word not at reset value");
	foreign_quiet_a: assert property (s_foreign |=> q.st == S_IDLE)
		else $error("Reply to a foreign address");
	crc_quiet_a: assert property (s_crc_bad |=> q.st == S_IDLE)
		else $error("Reply to a corrupt request");
	start_low_a: assert property (s_tx_enter |-> !o_txd ##1 !o_txd)
		else $error("Start bit shorter than two cycles");
	cfg_hold_a: assert property (q.st == S_TX ##1 q.st == S_TX |-> $stable(q.cfg))
		else $error("Settings changed during reply");
	rate_legal_a: assert property (cfg_rate(q.cfg) >= RC_1200 && cfg_rate(q.cfg) <= RC_9600)
		else $error("Unsupported rate code in force");
	led_follow_a: assert property (q.st == S_TX |-> o_led == o_txd)
		else $error("Indicator not following transmit data");
	led_steady_a: assert property (q.st != S_TX |-> o_led)
		else $error("Indicator off while not sending");
	pulse_start_a: assert property (i_ce && i_energy_tick |=> o_energy_pulse_out
		&& (q.en != $past(q.en) || $past(i_nv_load)))
		else $error("Energy tick gave no pulse");
	energy_inc_a: assert property (i_ce && i_energy_tick && !i_nv_load
		|=> q.en == $past(q.en) + 32'h0000_0001)
		else $error("Energy count did not advance");
endmodule : mmc_regs
`default_nettype wire

// ### mmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master stand-in: sends framed requests, decodes every reply byte
module mmc_host_model (
	// Clock and current link settings
	input wire logic i_core_clk,
	input wire logic [15:0] i_bit_cyc,
	input wire logic [1:0] i_fmt,
	// Serial link seen from the host
	output logic o_rxd,
	input wire logic i_txd,
	input wire logic i_led,
	// Decoded reply bytes
	output logic [7:0] o_byte,
	output logic o_byte_ok,
	output logic o_byte_vld,
	output logic o_busy
);
	logic [7:0] d; // Byte under decode
	logic ok; // Framing and indicator verdict

	// ----------------------------------------
	// Check field
	// ----------------------------------------
	function automatic logic [15:0] crc16(input logic [7:0] b [24], input int n);
		logic [15:0] c;
		c = 16'hFFFF; // Preset all ones
		for (int k = 0; k < n; k++) begin
			c = c ^ {8'h00, b[k]};
			for (int i = 0; i < 8; i++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1); // Right shift, reflected
			end
		end
		return c;
	endfunction : crc16

	// One bit on the line, held a full bit time
	task automatic bit_out(input logic v);
		o_rxd <= v;
		repeat (i_bit_cyc) @(posedge i_core_clk);
	endtask : bit_out

	// Whole request, CRC appended; bad flips one check bit on purpose
	task automatic send(input logic [7:0] b [24], input int n, input logic bad);
		logic [15:0] c;
		logic [7:0] bt;
		c = crc16(b, n) ^ {15'h0000, bad};
		b[n] = c[7:0]; // Low byte first
		b[n + 1] = c[15:8];
		@(posedge i_core_clk);
		for (int k = 0; k < n + 2; k++) begin
			bt = b[k];
			bit_out(1'b0);
			for (int i = 0; i < 8; i++) begin
				bit_out(bt[i]);
			end
			// Parity only in the two parity formats
			if (i_fmt == 2'h1) begin
				bit_out(^bt);
			end
			if (i_fmt == 2'h2) begin
				bit_out(~^bt);
			end
			bit_out(1'b1);
			if (i_fmt == 2'h3) begin
				bit_out(1'b1);
			end
		end
	endtask : send

	// ----------------------------------------
	// Reply decoder
	// ----------------------------------------
	// Samples mid-bit; a short half period still lands before the next start edge
	initial begin
		o_rxd = 1'b1;
		o_byte = 8'h00;
		o_byte_ok = 1'b0;
		o_byte_vld = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(negedge i_txd);
			o_busy <= 1'b1;
			repeat (i_bit_cyc / 2) @(posedge i_core_clk);
			ok = !i_txd && !i_led;
			for (int i = 0; i < 8; i++) begin
				repeat (i_bit_cyc) @(posedge i_core_clk);
				d[i] = i_txd;
			end
			if (i_fmt == 2'h1 || i_fmt == 2'h2) begin
				repeat (i_bit_cyc) @(posedge i_core_clk);
				ok = ok && (i_txd === (^d ^ (i_fmt == 2'h2)));
			end
			repeat (i_bit_cyc) @(posedge i_core_clk);
			ok = ok && i_txd;
			if (i_fmt == 2'h3) begin
				repeat (i_bit_cyc) @(posedge i_core_clk);
				ok = ok && i_txd;
			end
			o_byte <= d;
			o_byte_ok <= ok;
			o_byte_vld <= 1'b1;
			@(posedge i_core_clk);
			o_byte_vld <= 1'b0;
			o_busy <= 1'b0;
		end
	end
endmodule : mmc_host_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mmc_pkg::*;
	localparam int TB_CLK_HZ = 48000; // Five cycles a bit at 9600
	localparam int TB_PULSE = 4;
	localparam logic [15:0] TB_ID_A = 16'h6C11; // Arbitrary identity value
	localparam logic [15:0] TB_ID_B = 16'h6C22; // Arbitrary identity value
	localparam logic [31:0] BAD_TAB [6] = '{32'h02030001, 32'h00030001, 32'h01030001,
		32'h01040001, 32'h01030402, 32'h01030000};
	localparam logic [15:0] WR_TAB [3] = '{16'h0107, 16'h0102, 16'h0005};
	localparam logic [15:0] CFG_TAB [4] = '{16'h2246, 16'h3383, 16'h44C4, 16'h0105};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rxd, txd, led, tick, nv_load, pulse, hvld, hok, hbusy, ce;
	logic [31:0] nv_val, energy;
	logic [15:0] cfg, upd, ct, bit_cyc;
	logic [1:0] fmt;
	logic [7:0] hbyte, e8;
	logic [7:0] q [24]; // Request bytes
	logic [7:0] r [24]; // Expected reply bytes
	logic [7:0] exp_q [$]; // Reply bytes still owed
	int error_cnt = 0;
	int checks = 0;

	always #25 clk = ~clk;

	mmc_regs #(.P_CLK_HZ(TB_CLK_HZ), .P_PULSE_CYC(TB_PULSE), .P_MODEL_A(TB_ID_A),
		.P_MODEL_B(TB_ID_B)) DUT (.i_core_clk(clk), .i_ce(ce), .i_sys_rst(rst),
		.i_rxd(rxd), .o_txd(txd), .o_led(led), .i_energy_tick(tick), .i_nv_load(nv_load),
		.i_nv_energy(nv_val), .o_energy(energy), .o_energy_pulse_out(pulse),
		.o_cfg_word(cfg), .o_update_ms(upd), .o_ct_ratio(ct));

	mmc_host_model host (.i_core_clk(clk), .i_bit_cyc(bit_cyc), .i_fmt(fmt), .o_rxd(rxd),
		.i_txd(txd), .i_led(led), .o_byte(hbyte), .o_byte_ok(hok), .o_byte_vld(hvld),
		.o_busy(hbusy));

	// ----------------------------------------
	// Comparison and closing
	// ----------------------------------------
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected reply byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic finish_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	// Every decoded byte takes the oldest note; an empty queue yields x and fails
	always @(posedge clk) begin
		if (hvld) begin
			e8 = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
			chk_byte(hbyte, e8);
			chk_val({31'h0, hok}, 32'h1);
		end
	end

	// ----------------------------------------
	// Transfer helpers
	// ----------------------------------------
	function automatic logic [15:0] rate_cyc(input logic [3:0] rc);
		case (rc)
			RC_1200: return 16'(TB_CLK_HZ / BAUD_1200);
			RC_2400: return 16'(TB_CLK_HZ / BAUD_2400);
			RC_4800: return 16'(TB_CLK_HZ / BAUD_4800);
			default: return 16'(TB_CLK_HZ / BAUD_9600);
		endcase
	endfunction : rate_cyc

	// Waits for owed bytes, then leaves a long idle so strays are caught
	task automatic wait_idle;
		int n;
		n = 0;
		while ((exp_q.size() != 0 || hbusy) && n < 40000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40000) begin
			error_cnt++;
			$display("unexpected hang at %0t: got %h expected %h", $time, exp_q.size(), 0);
			finish_test();
		end
		repeat (60 * bit_cyc) @(posedge clk);
	endtask : wait_idle

	task automatic xfer(input int n, input int m, input logic bad);
		logic [15:0] c;
		c = host.crc16(r, m);
		for (int k = 0; k < m; k++) begin
			exp_q.push_back(r[k]);
		end
		if (m > 0) begin
			exp_q.push_back(c[7:0]);
			exp_q.push_back(c[15:8]);
		end
		host.send(q, n, bad);
		wait_idle();
	endtask : xfer

	task automatic req(input logic [7:0] a, input logic [7:0] fn, input logic [7:0] sa,
		input logic [7:0] qt);
		q[0] = a;
		q[1] = fn;
		q[2] = 8'h00;
		q[3] = sa;
		q[4] = 8'h00;
		q[5] = qt;
	endtask : req

	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		req(a, FN_WRITE, 8'h04, 8'h01);
		q[6] = WR_BCNT;
		q[7] = w[15:8];
		q[8] = w[7:0];
	endtask : wr

	task automatic put_w(input int i, input logic [15:0] w);
		r[i] = w[15:8];
		r[i + 1] = w[7:0];
	endtask : put_w

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] w, cur;
		int nt;
		logic [31:0] en_exp;
		tick = 1'b0;
		ce = 1'b1;
		nv_load = 1'b0;
		nv_val = 32'h0;
		fmt = FMT_8N1;
		bit_cyc = rate_cyc(RC_4800);
		void'($urandom(57));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk_val(32'(cfg), 32'(CFG_RESET));
		chk_val({30'h0, txd, led}, 32'h3);
		chk_val(32'(pulse), 32'h0);
		chk_val(energy, 32'h0);
		chk_val({upd, ct}, {UPDATE_MS, CT_RATIO});
		// Identity, range and config words in one read
		req(8'h01, FN_READ, 8'h00, 8'h05);
		r[0] = 8'h01;
		r[1] = FN_READ;
		r[2] = 8'h0A;
		put_w(3, TB_ID_A);
		put_w(5, TB_ID_B);
		put_w(7, VRANGE_V);
		put_w(9, IRANGE_DA);
		put_w(11, CFG_RESET);
		xfer(6, 13, 1'b0);
		// Requests that must stay unanswered
		for (int k = 0; k < 6; k++) begin
			req(BAD_TAB[k][31:24], BAD_TAB[k][23:16], BAD_TAB[k][15:8], BAD_TAB[k][7:0]);
			xfer(6, 0, k == 2);
		end
		// Energy: random restore, a random burst of ticks, then the pulse window
		nt = $urandom_range(8, 1);
		@(posedge clk);
		nv_val <= $urandom();
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		tick <= 1'b1;
		repeat (nt) @(posedge clk);
		tick <= 1'b0;
		@(negedge clk);
		en_exp = nv_val + 32'(nt);
		chk_val(energy, en_exp);
		chk_val(32'(pulse), 32'h1);
		repeat (TB_PULSE - 1) @(posedge clk);
		@(negedge clk);
		chk_val(32'(pulse), 32'h1);
		@(posedge clk);
		@(negedge clk);
		chk_val(32'(pulse), 32'h0);
		// Enable low: ticks are ignored and every counter stays put
		@(posedge clk);
		ce <= 1'b0;
		tick <= 1'b1;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		tick <= 1'b0;
		@(negedge clk);
		chk_val(energy, en_exp);
		chk_val(32'(pulse), 32'h0);
		req(8'h01, FN_READ, 8'h0C, 8'h02);
		r[2] = 8'h04;
		put_w(3, en_exp[31:16]);
		put_w(5, en_exp[15:0]);
		xfer(6, 7, 1'b0);
		// Writes with unusable data leave the word alone
		for (int k = 0; k < 3; k++) begin
			wr(8'h01, WR_TAB[k]);
			xfer(9, 0, 1'b0);
			chk_val(32'(cfg), 32'(CFG_RESET));
		end
		// Every format and rate; last step is a silent broadcast back to defaults
		cur = CFG_RESET;
		for (int k = 0; k < 4; k++) begin
			w = CFG_TAB[k];
			wr((k == 3) ? ADDR_BCAST : cur[15:8], w);
			for (int i = 0; i < 6; i++) begin
				r[i] = q[i];
			end
			xfer(9, (k == 3) ? 0 : 6, 1'b0);
			chk_val(32'(cfg), 32'(w));
			cur = w;
			fmt = w[7:6];
			bit_cyc = rate_cyc(w[3:0]);
			req(w[15:8], FN_READ, 8'h04, 8'h01);
			r[0] = w[15:8];
			r[1] = FN_READ;
			r[2] = 8'h02;
			put_w(3, w);
			xfer(6, 5, 1'b0);
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
